// ### uart_frame_header_decoder.sv
/*
 * Slave-side frame header decoder: auto-baud on the sync byte, target-select and command
 * decode, frame timeout, input debounce, LED output mapping, fault reaction, end dimming.
 * Assumes all inputs are synchronous to clk and a single bus master on the serial line.
 */
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "frame_decoder_defines.svh"

module uart_frame_header_decoder import frame_decoder_pkg::*; #(
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic uart_rx,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic enable_input,
    input wire logic [1:0] pattern_select_input,
    input wire logic animation_start_input,
    input wire logic animation_done_signal,
    output logic [4:0] inputs_clean,
    input wire logic [11:0] pattern_word,
    input wire logic last_vector,
    input wire logic local_fault,
    input wire logic fault_bus,
    output logic anim_stop,
    output logic [11:0] led_out,
    output logic [11:0] led_oe,
    output frame_hdr_s hdr,
    output logic [3:0] cmd_code,
    output logic cmd_valid,
    output logic ack_req,
    output logic [7:0] data_byte,
    output logic data_valid
);
    localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);

    logic [8:0] ctrl_r;
    logic [15:0] dim_delay_r, dim_step_r;
    logic [7:0] dim_duty_r;
    logic [4:0] irq_status_r, irq_en_r, ev_all;
    logic rx_q, rx_prev, rx_fall;
    frame_state_e state_r;
    logic [19:0] meas_r;
    logic [1:0] falls_r;
    logic [15:0] bit_period_r;
    logic rx_busy_r, byte_valid_r;
    logic [15:0] rx_cnt_r;
    logic [3:0] rx_bitn_r;
    logic [7:0] rx_sh_r;
    logic [15:0] ft_cnt_r;
    logic [11:0] ft_bits_r, ft_limit_r;
    logic timeout;
    logic sel_r;
    logic [8:0] data_left_r;
    logic [7:0] crc_r, cmd_byte_r;
    logic [DBW-1:0] db_cnt_r [5];
    logic [4:0] db_raw;
    logic [6:0] tick_div_r;
    logic tick;
    logic [15:0] dim_cnt_r;
    logic dim_wait_r, dim_run_r;
    logic [8:0] dim_level_r;
    logic [7:0] pwm_r;
    logic stopped, fault_prev_r;
    logic [11:0] mapped, lit;

    // Serial line edge detection
    assign rx_fall = rx_prev & ~rx_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_q <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_q <= uart_rx;
            rx_prev <= rx_q;
        end
    end

    // Byte receiver at the measured bit period
    always_ff @(posedge clk) begin
        byte_valid_r <= 1'b0;
        if (sys_rst || state_r == ST_HUNT || state_r == ST_SYNC || timeout) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bitn_r <= 4'h0;
            rx_sh_r <= 8'h00;
        end else if (!rx_busy_r) begin
            if (rx_fall) begin
                rx_busy_r <= 1'b1;
                rx_cnt_r <= {1'b0, bit_period_r[15:1]};
                rx_bitn_r <= 4'h0;
            end
        end else if (rx_cnt_r != 16'h0000) begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
        end else begin
            rx_cnt_r <= bit_period_r - 16'h0001;
            rx_bitn_r <= rx_bitn_r + 4'h1;
            if (rx_bitn_r == 4'h0 && rx_q)
                rx_busy_r <= 1'b0;
            else if (rx_bitn_r >= 4'h1 && rx_bitn_r <= 4'h8)
                rx_sh_r <= {rx_q, rx_sh_r[7:1]};
            else if (rx_bitn_r == 4'h9) begin
                rx_busy_r <= 1'b0;
                byte_valid_r <= rx_q;
            end
        end
    end

    // Frame timer in bit times
    always_ff @(posedge clk) begin
        if (sys_rst || state_r == ST_HUNT) begin
            ft_cnt_r <= 16'h0000;
            ft_bits_r <= 12'h000;
        end else if (state_r != ST_SYNC) begin
            if (ft_cnt_r >= bit_period_r - 16'h0001) begin
                ft_cnt_r <= 16'h0000;
                ft_bits_r <= ft_bits_r + 12'h001;
            end else begin
                ft_cnt_r <= ft_cnt_r + 16'h0001;
            end
        end
    end
    assign timeout = (state_r != ST_HUNT) && (state_r != ST_SYNC) && (ft_bits_r >= ft_limit_r);

    // Frame sequencer
    always_ff @(posedge clk) begin
        cmd_valid <= 1'b0;
        ack_req <= 1'b0;
        data_valid <= 1'b0;
        if (sys_rst) begin
            state_r <= ST_HUNT;
            meas_r <= 20'h00000;
            falls_r <= 2'h0;
            bit_period_r <= 16'h0001;
            sel_r <= 1'b0;
            data_left_r <= 9'h000;
            crc_r <= 8'h00;
            cmd_byte_r <= 8'h00;
            ft_limit_r <= 12'h000;
            hdr <= '0;
            cmd_code <= 4'h0;
            data_byte <= 8'h00;
        end else if (timeout) begin
            state_r <= ST_HUNT;
        end else begin
            case (state_r)
                ST_HUNT: if (rx_fall) begin
                    state_r <= ST_SYNC;
                    meas_r <= 20'h00000;
                    falls_r <= 2'h0;
                end
                ST_SYNC: begin
                    meas_r <= meas_r + 20'h00001;
                    if (&meas_r)
                        state_r <= ST_HUNT;
                    else if (rx_fall) begin
                        falls_r <= falls_r + 2'h1;
                        if (falls_r == 2'h3) begin
                            bit_period_r <= meas_r[18:3] + 16'h0001;
                            ft_limit_r <= 12'(4 * `TIMEOUT_BITS_PER_BYTE);
                            state_r <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR: if (byte_valid_r) begin
                    hdr <= rx_sh_r;
                    sel_r <= rx_sh_r[6] || (rx_sh_r[3:0] == ctrl_r[3:0]);
                    crc_r <= rx_sh_r;
                    case (rx_sh_r[5:4])
                        LEN_NONE: data_left_r <= 9'd0;
                        LEN_TWO: data_left_r <= 9'd2;
                        LEN_BURST8: data_left_r <= 9'd8;
                        default: data_left_r <= 9'd256;
                    endcase
                    case (rx_sh_r[5:4])
                        LEN_NONE: ft_limit_r <= 12'(4 * `TIMEOUT_BITS_PER_BYTE);
                        LEN_TWO: ft_limit_r <= 12'(6 * `TIMEOUT_BITS_PER_BYTE);
                        LEN_BURST8: ft_limit_r <= 12'(12 * `TIMEOUT_BITS_PER_BYTE);
                        default: ft_limit_r <= 12'(260 * `TIMEOUT_BITS_PER_BYTE);
                    endcase
                    state_r <= ST_CMD;
                end
                ST_CMD: if (byte_valid_r) begin
                    cmd_byte_r <= rx_sh_r;
                    state_r <= (data_left_r == 9'd0) ? ST_CRC : ST_DATA;
                end
                ST_DATA: if (byte_valid_r) begin
                    crc_r <= crc_r + rx_sh_r;
                    data_byte <= rx_sh_r;
                    data_valid <= sel_r;
                    data_left_r <= data_left_r - 9'd1;
                    if (data_left_r == 9'd1)
                        state_r <= ST_CRC;
                end
                ST_CRC: if (byte_valid_r) begin
                    if (rx_sh_r == crc_r && sel_r && cmd_byte_r[7:4] == 4'h0) begin
                        ack_req <= 1'b1;
                        cmd_valid <= 1'b1;
                        cmd_code <= cmd_byte_r[3:0];
                    end
                    state_r <= ST_HUNT;
                end
                default: state_r <= ST_HUNT;
            endcase
        end
    end

    // Input debounce
    assign db_raw = {animation_done_signal, animation_start_input, pattern_select_input,
                     enable_input};
    for (genvar i = 0; i < 5; i++) begin : g_db
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                db_cnt_r[i] <= '0;
                inputs_clean[i] <= 1'b0;
            end else if (db_raw[i] == inputs_clean[i]) begin
                db_cnt_r[i] <= '0;
            end else if (db_cnt_r[i] == DBW'(DEBOUNCE_CYCLES - 1)) begin
                db_cnt_r[i] <= '0;
                inputs_clean[i] <= db_raw[i];
            end else begin
                db_cnt_r[i] <= db_cnt_r[i] + 1'b1;
            end
        end
    end

    // Dimming time base and sequencer
    assign tick = (tick_div_r == 7'(`DIM_TICK_CYC - 1));
    always_ff @(posedge clk) begin
        if (sys_rst || tick)
            tick_div_r <= 7'h00;
        else
            tick_div_r <= tick_div_r + 7'h01;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dim_wait_r <= 1'b0;
            dim_run_r <= 1'b0;
            dim_cnt_r <= 16'h0000;
            dim_level_r <= 9'h100;
        end else if (animation_start_input) begin
            dim_wait_r <= 1'b0;
            dim_run_r <= 1'b0;
            dim_level_r <= 9'h100;
        end else if (last_vector && ctrl_r[`CTRL_DIM_EN]) begin
            dim_wait_r <= 1'b1;
            dim_cnt_r <= dim_delay_r;
        end else if (tick && (dim_wait_r || dim_run_r)) begin
            if (dim_cnt_r != 16'h0000) begin
                dim_cnt_r <= dim_cnt_r - 16'h0001;
            end else if (dim_wait_r) begin
                dim_wait_r <= 1'b0;
                dim_run_r <= 1'b1;
                dim_cnt_r <= dim_step_r;
            end else begin
                dim_cnt_r <= dim_step_r;
                if (dim_level_r > {1'b0, dim_duty_r})
                    dim_level_r <= dim_level_r - {1'b0, dim_duty_r};
                else begin
                    dim_level_r <= 9'h000;
                    dim_run_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            pwm_r <= 8'h00;
        else
            pwm_r <= pwm_r + 8'h01;
    end

    // Output mapping, polarity and fault reaction
    assign stopped = local_fault || (ctrl_r[`CTRL_ALL_STOP] && fault_bus);
    for (genvar j = 0; j < 12; j++) begin : g_map
        assign mapped[j] = ctrl_r[`CTRL_MSB_FIRST] ? pattern_word[11-j] : pattern_word[j];
    end
    assign lit = mapped & {12{({1'b0, pwm_r} < dim_level_r)}};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            led_out <= 12'h000;
            led_oe <= 12'h000;
            anim_stop <= 1'b0;
            fault_prev_r <= 1'b0;
        end else begin
            anim_stop <= stopped;
            fault_prev_r <= stopped;
            led_oe <= (stopped && ctrl_r[`CTRL_FAULT_HIZ]) ? 12'h000 : 12'hFFF;
            if (stopped)
                led_out <= ctrl_r[`CTRL_ACTIVE_HIGH] ? 12'h000 : 12'hFFF;
            else
                led_out <= ctrl_r[`CTRL_ACTIVE_HIGH] ? lit : ~lit;
        end
    end

    // Register port and interrupt
    // One-cycle events: dim done, fault onset, timeout, bad checksum, accepted frame
    assign ev_all = {dim_run_r && tick && dim_cnt_r == 16'h0000 &&
                     dim_level_r <= {1'b0, dim_duty_r},
                     stopped & ~fault_prev_r, timeout,
                     state_r == ST_CRC && byte_valid_r && !timeout && rx_sh_r != crc_r,
                     ack_req};

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= 32'h00000000;
        end else begin
            case (reg_addr)
                `REG_CTRL: reg_rdata <= {23'h000000, ctrl_r};
                `REG_DIM_DELAY: reg_rdata <= {16'h0000, dim_delay_r};
                `REG_DIM_STEP: reg_rdata <= {16'h0000, dim_step_r};
                `REG_DIM_DUTY: reg_rdata <= {24'h000000, dim_duty_r};
                `REG_IRQ_STATUS: reg_rdata <= {27'h0000000, irq_status_r};
                `REG_IRQ_ENABLE: reg_rdata <= {27'h0000000, irq_en_r};
                `REG_LINK_INFO: reg_rdata <= {16'h0000, bit_period_r};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= `CTRL_RESET;
            dim_delay_r <= 16'h0000;
            dim_step_r <= 16'h0000;
            dim_duty_r <= 8'h00;
            irq_en_r <= 5'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_CTRL: ctrl_r <= reg_wdata[8:0];
                `REG_DIM_DELAY: dim_delay_r <= reg_wdata[15:0];
                `REG_DIM_STEP: dim_step_r <= reg_wdata[15:0];
                `REG_DIM_DUTY: dim_duty_r <= reg_wdata[7:0];
                `REG_IRQ_ENABLE: irq_en_r <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_status_r <= 5'h00;
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_en_r);
            if (reg_wr && reg_addr == `REG_IRQ_CLEAR)
                irq_status_r <= (irq_status_r & ~reg_wdata[4:0]) | ev_all;
            else
                irq_status_r <= irq_status_r | ev_all;
        end
    end

    chk_sync_retune: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_SYNC && rx_fall && falls_r == 2'h3 && !(&meas_r))
        |=> state_r == ST_ADDR) else $error("sync byte did not start a frame");
    chk_period_set: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_SYNC && rx_fall && falls_r == 2'h3 && !(&meas_r))
        |=> bit_period_r == $past(meas_r[18:3]) + 16'h0001) else $error("bit period not set");
    chk_cmd_upper: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid |-> $past(cmd_byte_r[7:4]) == 4'h0) else $error("command with upper bits");
    chk_unsel_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        (data_valid || ack_req) |-> sel_r) else $error("unaddressed slave answered");
    chk_timeout_hunt: assert property (@(posedge clk) disable iff (sys_rst)
        timeout |=> state_r == ST_HUNT) else $error("timeout did not drop frame");
    chk_fault_hiz: assert property (@(posedge clk) disable iff (sys_rst)
        (stopped && ctrl_r[`CTRL_FAULT_HIZ]) |=> led_oe == 12'h000) else $error("outputs driven");
    chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> irq == $past(|(irq_status_r & irq_en_r))) else $error("irq level wrong");
    cov_frame_ack: cover property (@(posedge clk) disable iff (sys_rst) ack_req);
    cov_timeout: cover property (@(posedge clk) disable iff (sys_rst) timeout);
    cov_dim_done: cover property (@(posedge clk) disable iff (sys_rst) ev_all[`EV_DIM_DONE]);
endmodule : uart_frame_header_decoder

// ### frame_decoder_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the frame header decoder.
 * Assumes a 125 MHz core clock and a byte-addressed register port with 32-bit data.
 */
`ifndef FRAME_DECODER_DEFINES_SVH
`define FRAME_DECODER_DEFINES_SVH

`define SYNC_BYTE 8'h55
`define CLK_PERIOD_NS 8
`define DEBOUNCE_US 530
`define DEBOUNCE_CYC ((`DEBOUNCE_US * 1000) / `CLK_PERIOD_NS)
`define DIM_TICK_NS 1000
`define DIM_TICK_CYC (`DIM_TICK_NS / `CLK_PERIOD_NS)
`define TIMEOUT_BITS_PER_BYTE 15

`define REG_CTRL 8'h00
`define REG_DIM_DELAY 8'h04
`define REG_DIM_STEP 8'h08
`define REG_DIM_DUTY 8'h0C
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_CLEAR 8'h14
`define REG_IRQ_ENABLE 8'h18
`define REG_LINK_INFO 8'h1C

`define CTRL_ADDR_LSB 0
`define CTRL_ACTIVE_HIGH 4
`define CTRL_MSB_FIRST 5
`define CTRL_ALL_STOP 6
`define CTRL_FAULT_HIZ 7
`define CTRL_DIM_EN 8
`define CTRL_RESET 9'h030

`define EV_FRAME_OK 0
`define EV_FRAME_BAD 1
`define EV_TIMEOUT 2
`define EV_FAULT 3
`define EV_DIM_DONE 4

`endif

// ### frame_decoder_pkg.sv
/*
 * Types shared by the frame header decoder: header layout, commands, frame states.
 * Assumes frame_decoder_defines.svh supplies the numeric constants.
 */
package frame_decoder_pkg;
    typedef enum logic [1:0] {
        LEN_NONE = 2'h0, LEN_TWO = 2'h1, LEN_BURST8 = 2'h2, LEN_BURST256 = 2'h3
    } data_len_e;

    typedef struct packed {
        logic write;
        logic broadcast;
        data_len_e len;
        logic [3:0] addr;
    } frame_hdr_s;

    typedef enum logic [3:0] {
        position_detect_reset_cmd = 4'h0, position_detect_step_cmd = 4'h1,
        position_detect_end_cmd = 4'h2, prog_info_block_first_frame_cmd = 4'h3,
        prog_info_block_cont_frame_cmd = 4'h4, prog_first_frame_cmd = 4'h5,
        prog_cont_frame_cmd = 4'h6, part_number_read_cmd = 4'h7, firmware_version_read_cmd = 4'h8
    } cmd_code_e;

    typedef enum logic [5:0] {
        ST_HUNT = 6'h01, ST_SYNC = 6'h02, ST_ADDR = 6'h04,
        ST_CMD = 6'h08, ST_DATA = 6'h10, ST_CRC = 6'h20
    } frame_state_e;
endpackage : frame_decoder_pkg

// ### host_uart_model.sv
/* Host bus master model: sends 8N1 bytes on the shared serial line.
   Assumes the bench calls its tasks; the line idles high between bytes. */
`timescale 1ns/1ps
module host_uart_model (
    input wire logic clk,
    output logic tx
);
    int bit_cyc = 24;
    initial tx = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            tx <= sh[i];
            repeat (bit_cyc - 1) @(posedge clk);
        end
    endtask : send_byte
    task automatic sync();
        send_byte(8'h55);
    endtask : sync
    // Quiet line before the next frame; long gaps wait out the receiver timeout
    task automatic idle(input int bits);
        repeat (bits * bit_cyc) @(posedge clk);
    endtask : idle
endmodule : host_uart_model

// ### uart_frame_header_decoder_bench.sv
/* Self-checking bench: frame decode, LED mapping, faults, debounce, interrupts.
   Assumes host_uart_model drives the serial line and a 125 MHz clock. */
`timescale 1ns/1ps
`include "frame_decoder_defines.svh"
module uart_frame_header_decoder_bench import frame_decoder_pkg::*; ;
    localparam int DB = 50;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic uart_rx, irq, cmd_valid, ack_req, data_valid, anim_stop;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic local_fault = 1'b0;
    logic last_vector = 1'b0;
    logic fault_bus = 1'b0;
    logic [4:0] ins = 5'h00;
    logic [4:0] inputs_clean;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] sel, data_byte;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [11:0] pattern_word = 12'h000;
    logic [11:0] led_out, led_oe, e;
    frame_hdr_s hdr;
    logic [3:0] cmd_code;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 75;
    logic [11:0] exp_cmd[$];
    logic [7:0] exp_dat[$];
    logic [63:0] exp_rd[$];

    host_uart_model host_u (.clk(clk), .tx(uart_rx));
    uart_frame_header_decoder #(.DEBOUNCE_CYCLES(DB)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .uart_rx(uart_rx), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .enable_input(ins[4]), .pattern_select_input(ins[3:2]),
        .animation_start_input(ins[1]), .animation_done_signal(ins[0]),
        .inputs_clean(inputs_clean), .pattern_word(pattern_word), .last_vector(last_vector),
        .local_fault(local_fault), .fault_bus(fault_bus), .anim_stop(anim_stop),
        .led_out(led_out), .led_oe(led_oe), .hdr(hdr), .cmd_code(cmd_code),
        .cmd_valid(cmd_valid), .ack_req(ack_req), .data_byte(data_byte),
        .data_valid(data_valid)
    );

    initial forever #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Expected read value and the mask of bits that matter
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_rd.push_back({m, x});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic frame(input logic [7:0] s, input logic [7:0] cmd, input bit hit);
        logic [7:0] d;
        logic [7:0] sum;
        int n;
        n = (s[5:4] == 2'h1) ? 2 : (s[5:4] == 2'h2) ? 8 : 0;
        sum = s;
        if (hit) exp_cmd.push_back({s, cmd[3:0]});
        host_u.sync();
        host_u.send_byte(s);
        host_u.send_byte(cmd);
        repeat (n) begin
            d = 8'($random(seed));
            if (hit) exp_dat.push_back(d);
            sum = sum + d;
            host_u.send_byte(d);
        end
        host_u.send_byte(sum);
        host_u.idle(20);
    endtask : frame

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle

    // Results are matched against the oldest note when they appear
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            check(reg_rdata & exp_rd[0][63:32], exp_rd[0][31:0], "rdata");
            exp_rd.pop_front();
        end
        if (!sys_rst && cmd_valid === 1'b1) begin
            if (exp_cmd.size() == 0) check(32'h1, 32'h0, "extra cmd");
            else check(32'({hdr, cmd_code}), 32'(exp_cmd.pop_front()), "cmd");
        end
        if (!sys_rst && data_valid === 1'b1) begin
            if (exp_dat.size() == 0) check(32'h1, 32'h0, "extra data");
            else check(32'(data_byte), 32'(exp_dat.pop_front()), "data");
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`REG_CTRL, 32'h1FF, 32'(`CTRL_RESET));
        rd(8'hFC, 32'hFFFFFFFF, 32'h0);
        wr(`REG_CTRL, 32'h35);
        for (int c = 0; c < 9; c++) begin
            sel = 8'($random(seed)) & 8'hDF;
            if (!sel[6]) sel[3:0] = 4'h5;
            frame(sel, 8'(c), 1'b1);
        end
        frame(8'h26, 8'h01, 1'b0);
        frame(8'h85, 8'h13, 1'b0);
        frame(8'hE0, 8'h05, 1'b1);
        host_u.sync();
        host_u.send_byte(8'h95);
        host_u.idle(200);
        rd(`REG_IRQ_STATUS, 32'h4, 32'h4);
        host_u.bit_cyc = 56;
        frame(8'h15, 8'h08, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(`REG_CTRL, 32'h5 | (32'(m) << 4));
            pattern_word <= 12'($random(seed));
            settle(4);
            for (int i = 0; i < 12; i++) e[i] = pattern_word[m[1] ? 11 - i : i] ^ !m[0];
            check(32'(led_out), 32'(e), "led");
        end
        wr(`REG_CTRL, 32'hF5);
        local_fault <= 1'b1;
        settle(4);
        check(32'(led_oe), 32'h0, "hiz");
        check(32'(anim_stop), 32'h1, "stop");
        rd(`REG_IRQ_STATUS, 32'h8, 32'h8);
        check(32'(irq), 32'h0, "irq masked");
        wr(`REG_IRQ_ENABLE, 32'h8);
        settle(2);
        check(32'(irq), 32'h1, "irq");
        wr(`REG_CTRL, 32'h35);
        settle(4);
        check(32'({led_oe, led_out}), 32'hFFF000, "inactive");
        local_fault <= 1'b0;
        fault_bus <= 1'b1;
        settle(4);
        check(32'(anim_stop), 32'h0, "continue");
        wr(`REG_CTRL, 32'h75);
        settle(4);
        check(32'(anim_stop), 32'h1, "all stop");
        fault_bus <= 1'b0;
        wr(`REG_IRQ_CLEAR, 32'h8);
        settle(2);
        check(32'(irq), 32'h0, "irq clear");
        rd(`REG_IRQ_STATUS, 32'h8, 32'h0);
        pattern_word <= 12'hFFF;
        wr(`REG_DIM_DELAY, 32'h1);
        wr(`REG_DIM_STEP, 32'h0);
        wr(`REG_DIM_DUTY, 32'h80);
        wr(`REG_CTRL, 32'h135);
        settle(4);
        check(32'(led_out), 32'hFFF, "lit before dim");
        last_vector <= 1'b1;
        settle(1);
        last_vector <= 1'b0;
        settle(700);
        check(32'(led_out), 32'h000, "dimmed");
        rd(`REG_IRQ_STATUS, 32'h10, 32'h10);
        ins <= 5'h1F;
        settle(DB / 2);
        ins <= 5'h00;
        settle(DB + 10);
        check(32'(inputs_clean), 32'h0, "glitch");
        ins <= 5'h1F;
        settle(DB - 5);
        check(32'(inputs_clean), 32'h0, "early");
        settle(15);
        check(32'(inputs_clean), 32'h1F, "stable");
        settle(4);
        check(32'(exp_cmd.size() + exp_dat.size()), 32'h0, "missing");
        wrap_up();
    end
endmodule : uart_frame_header_decoder_bench
